// *** design/adc_regs_pkg.sv ***
// Constants shared by the condition and configuration register logic
// ==========================================================================
package adc_regs_pkg;
    // ==========================================================================
    // Register addresses and sizes
    localparam logic [2:0] ADDR_FLAGS = 3'h0;
    localparam logic [2:0] ADDR_CONFIG = 3'h1;
    localparam logic [2:0] ADDR_RESULT = 3'h3;
    localparam int FLAGS_BITS = 8;
    localparam int CONFIG_BITS = 24;
    localparam int RESULT_BITS = 24;
    localparam logic [7:0] FLAGS_RESET = 8'h80;
    localparam logic [23:0] CONFIG_RESET = 24'h080060;
    localparam logic [23:0] CONFIG_WRITABLE = 24'hfcafff;

    // ==========================================================================
    // Command byte fields
    localparam int CMD_ENABLE_POS = 7;
    localparam int CMD_READ_POS = 6;
    localparam int CMD_ADDR_LSB = 3;

    // ==========================================================================
    // Condition register fields
    localparam int FLAG_PENDING_POS = 7;
    localparam int FLAG_CLAMP_POS = 6;
    localparam int FLAG_REFMISS_POS = 5;
    localparam int FLAG_PARITY_POS = 4;

    // ==========================================================================
    // Configuration register fields
    localparam int CFG_MODE_LSB = 21;
    localparam int CFG_APPEND_POS = 20;
    localparam int CFG_CLOCK_LSB = 18;
    localparam int CFG_FILTER_POS = 15;
    localparam int CFG_PARITY_POS = 13;
    localparam int CFG_SINGLE_POS = 11;
    localparam int CFG_NOTCH_POS = 10;
    localparam int CFG_RATE_LSB = 0;
    localparam logic [2:0] MODE_IDLE = 3'h4;
    localparam logic [2:0] MODE_POWER_DOWN = 3'h2;
endpackage : adc_regs_pkg

// *** design/pin_sync.sv ***
// Two-stage synchroniser with edge detection for slow outside pins
module pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] IDLE = '0
) (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic [WIDTH-1:0] pin_i,
    output logic [WIDTH-1:0] level_o,
    output logic [WIDTH-1:0] rise_o,
    output logic [WIDTH-1:0] fall_o
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    // ==========================================================================
    // First stage is read only by the second; edges come from stages two and three
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            stage1 <= IDLE;
            stage2 <= IDLE;
            stage3 <= IDLE;
        end else begin
            stage1 <= pin_i;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    assign level_o = stage2;
    assign rise_o = stage2 & ~stage3;
    assign fall_o = ~stage2 & stage3;
endmodule : pin_sync

// *** design/adc_status_mode_registers.sv ***
// Condition and configuration registers behind the three-wire serial port
module adc_status_mode_registers (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    // Serial link pins from the host
    input wire logic sclk_i,
    input wire logic din_i,
    input wire logic cs_n_i,
    input wire logic sync_n_i,
    output logic dout_rdy_o,
    output logic dout_rdy_oe_o,
    // Converter core, same clock
    input wire logic result_load_i,
    input wire logic [23:0] result_data_i,
    input wire logic result_clamped_i,
    input wire logic [2:0] result_channel_i,
    input wire logic result_update_warn_i,
    input wire logic reference_below_i,
    input wire logic reference_detect_enable_i,
    // Register contents towards the converter
    output logic [23:0] config_o,
    output logic [7:0] flags_o,
    output logic [23:0] stored_result_o,
    output logic modulator_reset_o
);
    typedef enum logic [2:0] {
        ST_COMMAND = 3'b001,
        ST_WRITE = 3'b010,
        ST_READ = 3'b100
    } serial_state_t;

    serial_state_t state;
    logic [5:0] bit_count;
    logic [5:0] bit_total;
    logic [6:0] cmd_shift;
    logic [23:0] write_shift;
    logic [31:0] read_shift;
    logic [2:0] access_addr;
    logic cmd_started;

    logic pending_n;
    logic clamp_flag;
    logic reference_missing_flag;
    logic parity_flag;
    logic [2:0] source_channel_tag;
    logic [23:0] operating_configuration;
    logic [23:0] result_reg;

    logic sclk_level;
    logic sclk_rise;
    logic cs_n_level;
    logic sync_n_level;
    logic din_level;

    logic cmd_done;
    logic write_done;
    logic read_done;
    logic mode_halted;
    logic [7:0] flag_byte;
    logic [23:0] next_result;

    // ==========================================================================
    // Pin synchronisers: every outside pin passes two flops first
    logic [2:0] unused_rise;
    pin_sync #(
        .WIDTH(4),
        .IDLE(4'hf)
    ) u_pin_sync (
        .sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n_i),
        .pin_i({sclk_i, cs_n_i, sync_n_i, din_i}),
        .level_o({sclk_level, cs_n_level, sync_n_level, din_level}),
        .rise_o({sclk_rise, unused_rise}),
        .fall_o()
    );

    // ==========================================================================
    // Decode helpers
    function automatic logic [5:0] read_length(input logic [2:0] addr, input logic append);
        begin
            case (addr)
                adc_regs_pkg::ADDR_FLAGS: read_length = 6'(adc_regs_pkg::FLAGS_BITS);
                adc_regs_pkg::ADDR_CONFIG: read_length = 6'(adc_regs_pkg::CONFIG_BITS);
                adc_regs_pkg::ADDR_RESULT: read_length = append ?
                    6'(adc_regs_pkg::RESULT_BITS + adc_regs_pkg::FLAGS_BITS) :
                    6'(adc_regs_pkg::RESULT_BITS);
                default: read_length = 6'(adc_regs_pkg::FLAGS_BITS);
            endcase
        end
    endfunction : read_length

    function automatic logic [5:0] write_length(input logic [2:0] addr);
        begin
            if (addr == adc_regs_pkg::ADDR_CONFIG) begin
                write_length = 6'(adc_regs_pkg::CONFIG_BITS);
            end else begin
                write_length = 6'(adc_regs_pkg::FLAGS_BITS);
            end
        end
    endfunction : write_length

    // Condition byte assembled from live flags, bit 3 hard zero
    assign flag_byte = {pending_n, clamp_flag, reference_missing_flag, parity_flag,
                        1'b0, source_channel_tag};

    // Idle or power-down modes hold the converter, so no result may be claimed ready
    assign mode_halted =
        (operating_configuration[adc_regs_pkg::CFG_MODE_LSB +: 3] == adc_regs_pkg::MODE_IDLE) ||
        (operating_configuration[adc_regs_pkg::CFG_MODE_LSB +: 3] ==
         adc_regs_pkg::MODE_POWER_DOWN);

    // A missing reference clamps the result to all ones
    assign next_result = reference_missing_flag ? 24'hffffff : result_data_i;

    assign cmd_done = (state == ST_COMMAND) && sclk_rise && !cs_n_level &&
                      cmd_started && (bit_count == 6'h07);
    assign write_done = (state == ST_WRITE) && sclk_rise && !cs_n_level &&
                        (bit_count == bit_total - 6'h01);
    assign read_done = (state == ST_READ) && sclk_rise && !cs_n_level &&
                       (bit_count == bit_total - 6'h01);

    // ==========================================================================
    // Serial state machine; data is taken on rising serial clock edges
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state <= ST_COMMAND;
            bit_count <= 6'h00;
            bit_total <= 6'h00;
            cmd_started <= 1'b0;
            access_addr <= 3'h0;
        end else if (cs_n_level) begin
            // Deselect abandons any partial transfer
            state <= ST_COMMAND;
            bit_count <= 6'h00;
            cmd_started <= 1'b0;
        end else if (sclk_rise) begin
            case (state)
                ST_COMMAND: begin
                    if (!cmd_started) begin
                        // Ones before the enable zero are ignored, guarding against noise
                        if (!din_level) begin
                            cmd_started <= 1'b1;
                            bit_count <= 6'h01;
                        end
                    end else if (cmd_done) begin
                        cmd_started <= 1'b0;
                        bit_count <= 6'h00;
                        access_addr <= cmd_shift[4:2];
                        if (cmd_shift[5]) begin
                            state <= ST_READ;
                            bit_total <= read_length(cmd_shift[4:2],
                                operating_configuration[adc_regs_pkg::CFG_APPEND_POS]);
                        end else begin
                            state <= ST_WRITE;
                            bit_total <= write_length(cmd_shift[4:2]);
                        end
                    end else begin
                        bit_count <= bit_count + 6'h01;
                    end
                end
                ST_WRITE, ST_READ: begin
                    if (write_done || read_done) begin
                        state <= ST_COMMAND;
                        bit_count <= 6'h00;
                    end else begin
                        bit_count <= bit_count + 6'h01;
                    end
                end
                default: begin
                    state <= ST_COMMAND;
                    bit_count <= 6'h00;
                end
            endcase
        end
    end

    // ==========================================================================
    // Command byte shifter: collects the seven bits after the enable zero
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cmd_shift <= 7'h00;
        end else if (state == ST_COMMAND && sclk_rise && cmd_started) begin
            cmd_shift <= {cmd_shift[5:0], din_level};
        end
    end

    // ==========================================================================
    // Write data shifter, most significant bit arrives first
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            write_shift <= 24'h000000;
        end else if (state == ST_WRITE && sclk_rise && !cs_n_level) begin
            write_shift <= {write_shift[22:0], din_level};
        end
    end

    // ==========================================================================
    // Read shifter: loaded at the end of the command, advanced after each sample
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            read_shift <= 32'h00000000;
        end else if (cmd_done && cmd_shift[5]) begin
            case (cmd_shift[4:2])
                adc_regs_pkg::ADDR_FLAGS: read_shift <= {flag_byte, 24'h000000};
                adc_regs_pkg::ADDR_CONFIG: read_shift <= {operating_configuration, 8'h00};
                adc_regs_pkg::ADDR_RESULT: read_shift <= {result_reg, flag_byte};
                default: read_shift <= 32'h00000000;
            endcase
        end else if (state == ST_READ && sclk_rise && !cs_n_level) begin
            read_shift <= {read_shift[30:0], 1'b0};
        end
    end

    // ==========================================================================
    // Configuration register; fixed-zero positions never take a one
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            operating_configuration <= adc_regs_pkg::CONFIG_RESET;
        end else if (write_done && access_addr == adc_regs_pkg::ADDR_CONFIG) begin
            operating_configuration <= {write_shift[22:0], din_level} &
                                       adc_regs_pkg::CONFIG_WRITABLE;
        end
    end

    // Modulator and filter restart pulse on every configuration write
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            modulator_reset_o <= 1'b0;
        end else begin
            modulator_reset_o <= write_done && (access_addr == adc_regs_pkg::ADDR_CONFIG);
        end
    end

    // ==========================================================================
    // Pending flag (active low ready); any setting cause wins over a clear
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pending_n <= adc_regs_pkg::FLAGS_RESET[adc_regs_pkg::FLAG_PENDING_POS];
        end else if ((read_done && access_addr == adc_regs_pkg::ADDR_RESULT) ||
                     result_update_warn_i) begin
            pending_n <= 1'b1;
        end else if (mode_halted || !sync_n_level) begin
            pending_n <= 1'b1;
        end else if (write_done && access_addr == adc_regs_pkg::ADDR_CONFIG) begin
            pending_n <= 1'b1;
        end else if (result_load_i) begin
            pending_n <= 1'b0;
        end
    end

    // ==========================================================================
    // Result capture with clamp, parity and channel tag written alongside
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            result_reg <= 24'h000000;
            clamp_flag <= adc_regs_pkg::FLAGS_RESET[adc_regs_pkg::FLAG_CLAMP_POS];
            parity_flag <= adc_regs_pkg::FLAGS_RESET[adc_regs_pkg::FLAG_PARITY_POS];
            source_channel_tag <= adc_regs_pkg::FLAGS_RESET[2:0];
        end else if (result_load_i) begin
            result_reg <= next_result;
            clamp_flag <= result_clamped_i || reference_missing_flag;
            parity_flag <= operating_configuration[adc_regs_pkg::CFG_PARITY_POS] &
                           (^next_result);
            source_channel_tag <= result_channel_i;
        end
    end

    // Reference detector only reports while detection is switched on
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            reference_missing_flag <=
                adc_regs_pkg::FLAGS_RESET[adc_regs_pkg::FLAG_REFMISS_POS];
        end else begin
            reference_missing_flag <= reference_detect_enable_i && reference_below_i;
        end
    end

    // ==========================================================================
    // Shared data/ready pin: read data while shifting, otherwise ready level
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            dout_rdy_o <= 1'b1;
            dout_rdy_oe_o <= 1'b0;
        end else begin
            dout_rdy_oe_o <= !cs_n_level;
            if (state == ST_READ && !read_done) begin
                dout_rdy_o <= read_shift[31];
            end else begin
                dout_rdy_o <= pending_n;
            end
        end
    end

    // Register views towards the converter core
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            config_o <= adc_regs_pkg::CONFIG_RESET;
            flags_o <= adc_regs_pkg::FLAGS_RESET;
            stored_result_o <= 24'h000000;
        end else begin
            config_o <= operating_configuration;
            flags_o <= flag_byte;
            stored_result_o <= result_reg;
        end
    end
endmodule : adc_status_mode_registers

// *** verif/adc_status_mode_registers_props.sv ***
// Checker for the condition and configuration register block
module adc_status_mode_registers_props (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic cs_n_i,
    input wire logic sync_n_i,
    input wire logic dout_rdy_o,
    input wire logic result_load_i,
    input wire logic [23:0] result_data_i,
    input wire logic [2:0] result_channel_i,
    input wire logic result_update_warn_i,
    input wire logic reference_detect_enable_i,
    input wire logic [23:0] config_o,
    input wire logic [7:0] flags_o,
    input wire logic [23:0] stored_result_o,
    input wire logic modulator_reset_o
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!reset_n_i);
    logic [23:0] last_data;
    logic [2:0] last_chan;
    logic halted;
    // ==========================================================================
    // Helper state
    // Last offered result, so output latency may float by one cycle
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            last_data <= 24'h000000;
            last_chan <= 3'h0;
        end else if (result_load_i) begin
            last_data <= result_data_i;
            last_chan <= result_channel_i;
        end
    end
    // Either halted mode must hold the pending flag
    assign halted = config_o[23:21] == adc_regs_pkg::MODE_IDLE ||
        config_o[23:21] == adc_regs_pkg::MODE_POWER_DOWN;
    // ==========================================================================
    // Properties
    a_bit3_zero: assert property (flags_o[3] == 1'b0)
        else $error("Condition bit 3 is set");
    a_fixed_zero: assert property ((config_o & 24'h035000) == 24'h000000)
        else $error("Fixed-zero configuration bit is set");
    a_load_clears: assert property (result_load_i && cs_n_i && sync_n_i &&
        !result_update_warn_i && !halted |-> ##[1:2] !flags_o[7])
        else $error("Pending flag not cleared by a result load");
    a_result_copy: assert property (result_load_i && !reference_detect_enable_i
        |-> ##[1:2] stored_result_o == last_data)
        else $error("Stored result differs from the loaded value");
    a_reference_missing_flag_ones: assert property (result_load_i ##1 flags_o[5]
        |-> ##1 stored_result_o == 24'hffffff)
        else $error("Result not forced to ones with reference missing");
    a_parity_odd: assert property (result_load_i && config_o[13] &&
        !reference_detect_enable_i |-> ##[1:2] flags_o[4] == ^last_data)
        else $error("Parity flag wrong");
    a_chan_tag: assert property (result_load_i |-> ##[1:2] flags_o[2:0] == last_chan)
        else $error("Channel tag not that of the stored result");
    a_warn_pending: assert property (result_update_warn_i |-> ##[1:3] flags_o[7])
        else $error("Update warning did not set pending");
    a_sync_pending: assert property ((!sync_n_i) [*6] |-> flags_o[7])
        else $error("Sync low did not set pending");
    a_halt_pending: assert property (halted [*4] |-> flags_o[7])
        else $error("Halted mode did not hold pending");
    a_write_resets: assert property ($changed(config_o) |-> $past(modulator_reset_o))
        else $error("Configuration write without modulator reset");
    a_reset_pending: assert property (modulator_reset_o |-> ##[0:2] flags_o[7])
        else $error("Configuration write did not set pending");
    a_ready_pin: assert property ((cs_n_i [*5] ##0 $stable(flags_o[7]) [*3])
        |-> dout_rdy_o == flags_o[7])
        else $error("Ready pin disagrees with pending flag");
endmodule : adc_status_mode_registers_props

bind adc_status_mode_registers adc_status_mode_registers_props props_u (
    .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .cs_n_i(cs_n_i), .sync_n_i(sync_n_i),
    .dout_rdy_o(dout_rdy_o), .result_load_i(result_load_i), .result_data_i(result_data_i),
    .result_channel_i(result_channel_i), .result_update_warn_i(result_update_warn_i),
    .reference_detect_enable_i(reference_detect_enable_i), .config_o(config_o),
    .flags_o(flags_o), .stored_result_o(stored_result_o),
    .modulator_reset_o(modulator_reset_o));

// *** verif/host_model.sv ***
// Host side of the three-wire serial link
module host_model (
    output logic sclk_o,
    output logic din_o,
    output logic cs_n_o,
    input wire logic dout_i
);
    timeunit 1ns;
    timeprecision 1ns;
    // Idle levels: clock and data high, device not selected
    initial begin
        sclk_o = 1'b1;
        din_o = 1'b1;
        cs_n_o = 1'b1;
    end
    // ==========================================================================
    // One frame: command byte then n data bits, MSB first in both directions
    // The 13 ns offset shifts each frame 13 ns against the system clock, so some frames still land on its edges
    task automatic frame(input logic [7:0] cmd, input int n, input logic [31:0] wdata,
            output logic [31:0] rdata);
        logic [39:0] tx;
        tx = {cmd, wdata << (32 - n)};
        rdata = 32'h00000000;
        #13 cs_n_o = 1'b0;
        #160;
        for (int i = 0; i < 8 + n; i++) begin
            sclk_o = 1'b0;
            din_o = tx[39 - i];
            #160 sclk_o = 1'b1;
            if (i >= 8) begin
                rdata = {rdata[30:0], dout_i};
            end
            #160;
        end
        cs_n_o = 1'b1;
        din_o = 1'b1; // Idle high so a stray clock cannot start a command
        #320;
    endtask : frame
    // Select the device without clocking and look at the ready pin
    task automatic poll(output logic r);
        #13 cs_n_o = 1'b0;
        #480 r = dout_i;
        cs_n_o = 1'b1;
        #320;
    endtask : poll
endmodule : host_model

// *** verif/adc_status_mode_registers_test.sv ***
// Self-checking bench for the condition and configuration register block
module adc_status_mode_registers_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk, reset_n = 1'b0, sync_n = 1'b1, load = 1'b0, clamped = 1'b0, warn = 1'b0;
    logic ref_below = 1'b0, ref_en = 1'b0, sclk, din, cs_n, dout, oe, modrst, b;
    logic [23:0] data = 24'h000000, cfg, res;
    logic [2:0] chan = 3'h0;
    logic [7:0] flags;
    logic [31:0] rd;
    wire logic dout_w;
    int num_errors = 0;
    int num_checks = 0;
    // Unselected pin reads as a toggling pattern, never a stale level
    assign dout_w = oe ? dout : sys_clk;
    adc_status_mode_registers dut_u (.sys_clk_i(sys_clk), .reset_n_i(reset_n), .sclk_i(sclk),
        .din_i(din), .cs_n_i(cs_n), .sync_n_i(sync_n), .dout_rdy_o(dout), .dout_rdy_oe_o(oe),
        .result_load_i(load), .result_data_i(data), .result_clamped_i(clamped),
        .result_channel_i(chan), .result_update_warn_i(warn), .reference_below_i(ref_below),
        .reference_detect_enable_i(ref_en), .config_o(cfg), .flags_o(flags),
        .stored_result_o(res), .modulator_reset_o(modrst));
    host_model host_u (.sclk_o(sclk), .din_o(din), .cs_n_o(cs_n), .dout_i(dout_w));
    // 25 MHz system clock
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    // ==========================================================================
    // Shared tasks
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic complete_run();
        $display("Checks %0d, errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : complete_run
    // Bounded wait on the pending flag; running out ends the run
    task automatic wait_pend(input logic v);
        for (int i = 0; i < 40 && flags[7] !== v; i++) begin
            @(posedge sys_clk);
            #1;
        end
        check("pending", flags[7], v);
        if (flags[7] !== v) begin
            complete_run();
        end
    endtask : wait_pend
    // One-cycle load pulse from the converter, then let the copies settle
    task automatic load_res(input logic [23:0] d, input logic cl, input logic [2:0] ch);
        @(posedge sys_clk);
        load <= 1'b1;
        data <= d;
        clamped <= cl;
        chan <= ch;
        @(posedge sys_clk);
        load <= 1'b0;
        repeat (3) @(posedge sys_clk);
        #1;
    endtask : load_res
    // ==========================================================================
    // Scenarios
    task automatic t_reset();
        check("flags", flags, 8'h80);
        check("config", cfg, 24'h080060);
        check("ready pin", dout, 1'b1);
        check("pin enable", oe, 1'b0);
        host_u.frame(8'h40, 8, 32'h0, rd);
        check("flags read", rd, 32'h00000080);
        host_u.frame(8'h48, 24, 32'h0, rd);
        check("config read", rd, 32'h00080060);
        host_u.frame(8'h60, 8, 32'h0, rd);
        check("unmapped read", rd, 32'h00000000);
    endtask : t_reset
    // Parity and appending enabled together, fixed-zero bits left zero
    task automatic t_config();
        host_u.frame(8'h08, 24, 32'h0034a555, rd);
        check("config", cfg, 24'h34a555);
        check("pending", flags[7], 1'b1);
        host_u.frame(8'h48, 24, 32'h0, rd);
        check("config read", rd, 32'h0034a555);
    endtask : t_config
    task automatic t_result_read();
        load_res(24'h000007, 1'b0, 3'h5);
        check("flags", flags, 8'h15);
        check("result", res, 24'h000007);
        host_u.poll(b);
        check("ready pin", b, 1'b0);
        host_u.frame(8'h58, 32, 32'h0, rd);
        check("result with flags", rd, 32'h00000715);
        wait_pend(1'b1);
    endtask : t_result_read
    task automatic t_reference();
        @(posedge sys_clk);
        ref_en <= 1'b1;
        ref_below <= 1'b1;
        load_res(24'h123456, 1'b0, 3'h2);
        check("result", res, 24'hffffff);
        check("flags", flags, 8'h62);
        ref_below <= 1'b0;
        load_res(24'h800000, 1'b1, 3'h1);
        check("flags", flags, 8'h51);
        load_res(24'h000003, 1'b0, 3'h6);
        check("flags", flags, 8'h06);
    endtask : t_reference
    task automatic t_set_causes();
        @(posedge sys_clk);
        warn <= 1'b1;
        @(posedge sys_clk);
        warn <= 1'b0;
        wait_pend(1'b1);
        load_res(24'h000001, 1'b0, 3'h0);
        sync_n <= 1'b0;
        wait_pend(1'b1);
        repeat (8) @(posedge sys_clk);
        sync_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        load_res(24'h000001, 1'b0, 3'h0);
        check("pending", flags[7], 1'b0);
        host_u.frame(8'h08, 24, 32'h00880060, rd);
        wait_pend(1'b1);
        load_res(24'h000001, 1'b0, 3'h0);
        check("pending", flags[7], 1'b1);
        // Power-down mode must hold pending as well
        host_u.frame(8'h08, 24, 32'h00480060, rd);
        check("config", cfg, 24'h480060);
        load_res(24'h000001, 1'b0, 3'h0);
        check("pending", flags[7], 1'b1);
    endtask : t_set_causes
    // ==========================================================================
    // Main sequence
    initial begin
        repeat (3) @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        #1;
        t_reset();
        t_config();
        t_result_read();
        t_reference();
        t_set_causes();
        complete_run();
    end
endmodule : adc_status_mode_registers_test
